// *** verilog/odl_top.sv ***
// Purpose: Output channel dividers, divider source select and per-input loss monitors
// Assumes: All pins sampled into aclk; aclk much faster than any sampled clock
// Notes:   Registers over AXI4-Lite; sticky loss flags are the interrupt status
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "odl_defines.svh"

// How it works
// - Four integer channels divide the source by a supported ratio, 1 to 160
// - Fifth channel divides by twice integer part plus 24-bit fraction
// - Source select 0 feeds dividers from loop two, 1 from loop one
// - Selected input is primary, the other input is secondary
// - Automatic mode may override the configured selection and pick itself
// - One loss detector per input, referenced to loop one by 5-bit ratio
// - Three or more consecutive missing expected edges declare the input lost
// - Zero differential input voltage also declares loss
// - Each input has a live loss flag and a sticky latched flag
// - Loss events raise the active-low interrupt output for inputs whose mask bit is set
// - Detectors run only while first loop bypass is cleared
// - Detectors see missing edges only, not wrong frequency
// - Loss clears after a programmable count of consecutive good periods
// - With bypass set, selection is manual and switching is not used
module odl_top (
  // Clock, reset, freeze
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  // AXI4-Lite write
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [`ODL_AW-1:0]    awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire odl_pkg::odl_word_t    wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output odl_pkg::odl_resp_e         bresp,
  // AXI4-Lite read
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [`ODL_AW-1:0]    araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output odl_pkg::odl_word_t         rdata,
  output odl_pkg::odl_resp_e         rresp,
  // Pins
  input  wire logic                  loop1_clk,
  input  wire logic                  loop2_clk,
  input  wire logic [1:0]            ref_clk_in,
  input  wire logic [1:0]            ref_diff_zero,
  // Outputs
  output logic [3:0]                 channel_out,
  output logic                       frac_out,
  output logic                       primary_sel,
  output logic                       interrupt_request_out_n
);
  import odl_pkg::*;

  function automatic logic int_ratio_ok(input logic [7:0] r);
    case (r)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0a, 8'h10, 8'h14, 8'h1e,
      8'h20, 8'h28, 8'h32, 8'h3c, 8'h40, 8'h50, 8'h64, 8'h78, 8'h80, 8'ha0: int_ratio_ok = 1'b1;
      default: int_ratio_ok = 1'b0;
    endcase
  endfunction

  function automatic odl_word_t merge(input odl_word_t old, input odl_word_t d,
                                     input logic [3:0] s);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) merge[8*b +: 8] = d[8*b +: 8];
    end
  endfunction

  // Pin synchronisers: a change counts once stages two and three agree
  logic [5:0] sy1_reg, sy2_reg, sy3_reg, filt_reg;
  wire  [5:0] pins      = {ref_diff_zero, ref_clk_in, loop2_clk, loop1_clk};
  wire  [5:0] agree     = ~(sy2_reg ^ sy3_reg);
  wire  [5:0] filt_next = (agree & sy3_reg) | (~agree & filt_reg);
  wire  [5:0] rise      = filt_next & ~filt_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_reg  <= 6'h00;
      sy2_reg  <= 6'h00;
      sy3_reg  <= 6'h00;
      filt_reg <= 6'h00;
    end else if (ce) begin
      sy1_reg  <= pins;
      sy2_reg  <= sy1_reg;
      sy3_reg  <= sy2_reg;
      filt_reg <= filt_next;
    end
  end

  // Configuration registers
  logic [3:0]  ctrl_reg;
  logic [7:0]  div_reg [4];
  logic [3:0]  fint_reg;
  logic [23:0] ffrac_reg;
  logic [4:0]  mon_reg [2];
  logic [7:0]  reval_reg;
  logic [1:0]  stat_reg, mask_reg;
  logic [1:0]  live_reg;

  wire src_sel  = ctrl_reg[`ODL_CTRL_DIVSEL];
  wire bypass   = ctrl_reg[`ODL_CTRL_BYP];
  wire auto_sel = ctrl_reg[`ODL_CTRL_AUTO] & ~bypass;
  wire src_rise = src_sel ? rise[0] : rise[1];
  wire src_lvl  = src_sel ? filt_reg[0] : filt_reg[1];

  // AXI4-Lite slave: address and data taken in either order, write answer two cycles after the last take, read answer one cycle later
  logic                aw_full_reg, w_full_reg;
  logic [`ODL_AW-1:0]  waddr_reg;
  odl_word_t           wdat_reg;
  logic [3:0]          wstb_reg;
  wire aw_take   = awvalid & awready;
  wire w_take    = wvalid & wready;
  wire do_wr     = aw_full_reg & w_full_reg & ~bvalid;
  wire aw_f_next = (aw_full_reg | aw_take) & ~do_wr;
  wire w_f_next  = (w_full_reg | w_take) & ~do_wr;
  wire bv_next   = do_wr | (bvalid & ~bready);
  wire ar_take   = arvalid & arready;
  wire rv_next   = ar_take | (rvalid & ~rready);

  wire wa_ctrl = waddr_reg == `ODL_CTRL;
  wire wa_frac = waddr_reg == `ODL_FRAC;
  wire wa_mon  = waddr_reg == `ODL_MON;
  wire wa_ist  = waddr_reg == `ODL_INT_STAT;
  wire wa_imsk = waddr_reg == `ODL_INT_MASK;
  wire wa_div  = (waddr_reg >= `ODL_DIV0) && (waddr_reg <= `ODL_DIV3) && (waddr_reg[1:0] == 2'h0);
  wire wa_ro   = waddr_reg == `ODL_STATUS;
  wire wa_ok   = wa_ctrl | wa_frac | wa_mon | wa_ist | wa_imsk | wa_div | wa_ro;
  wire [1:0] wa_dix = 2'(waddr_reg[`ODL_AW-1:2] - 4'h1);

  wire odl_word_t ctrl_w = merge({28'h0, ctrl_reg}, wdat_reg, wstb_reg);
  wire odl_word_t div_w  = merge({24'h0, div_reg[wa_dix]}, wdat_reg, wstb_reg);
  wire odl_word_t frac_w = merge({4'h0, fint_reg, ffrac_reg}, wdat_reg, wstb_reg);
  wire odl_word_t mon_w  = merge({8'h0, reval_reg, 3'h0, mon_reg[1], 3'h0, mon_reg[0]},
                                 wdat_reg, wstb_reg);
  wire odl_word_t ist_w  = wstb_reg[0] ? wdat_reg : 32'h0;
  wire odl_word_t msk_w  = merge({30'h0, mask_reg}, wdat_reg, wstb_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= ODL_OKAY;
      waddr_reg   <= '0;
      wdat_reg    <= 32'h0;
      wstb_reg    <= 4'h0;
    end else if (ce) begin
      aw_full_reg <= aw_f_next;
      w_full_reg  <= w_f_next;
      awready     <= ~aw_f_next & ~bv_next;
      wready      <= ~w_f_next & ~bv_next;
      bvalid      <= bv_next;
      if (do_wr) bresp <= wa_ok ? ODL_OKAY : ODL_SLVERR;
      if (aw_take) waddr_reg <= awaddr;
      if (w_take) begin
        wdat_reg <= wdata;
        wstb_reg <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= `ODL_CTRL_RST;
      div_reg   <= '{default: `ODL_DIV_RST};
      fint_reg  <= `ODL_FINT_RST;
      ffrac_reg <= `ODL_FFRAC_RST;
      mon_reg   <= '{default: `ODL_MON_RST};
      reval_reg <= `ODL_REVAL_RST;
      mask_reg  <= 2'h0;
    end else if (ce && do_wr) begin
      if (wa_ctrl) ctrl_reg <= ctrl_w[3:0];
      // Unsupported ratios are ignored so a channel never runs at an odd rate
      if (wa_div && int_ratio_ok(div_w[7:0])) div_reg[wa_dix] <= div_w[7:0];
      if (wa_frac && frac_w[27:24] != 4'h0 && frac_w[27:24] <= 4'he) begin
        fint_reg  <= frac_w[`ODL_FRAC_INT_LSB +: 4];
        ffrac_reg <= frac_w[23:0];
      end
      if (wa_mon) begin
        mon_reg[0] <= mon_w[4:0];
        mon_reg[1] <= mon_w[`ODL_MON1_LSB +: 5];
        reval_reg  <= mon_w[`ODL_REVAL_LSB +: 8];
      end
      if (wa_imsk) mask_reg <= msk_w[1:0];
    end
  end

  // Read path
  wire [`ODL_AW-1:0] ra = araddr;
  wire [1:0] ra_dix = 2'(ra[`ODL_AW-1:2] - 4'h1);
  wire ra_div = (ra >= `ODL_DIV0) && (ra <= `ODL_DIV3) && (ra[1:0] == 2'h0);
  odl_word_t rd_val;
  logic      rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    case (ra)
      `ODL_CTRL:     rd_val = {28'h0, ctrl_reg};
      `ODL_FRAC:     rd_val = {4'h0, fint_reg, ffrac_reg};
      `ODL_MON:      rd_val = {8'h0, reval_reg, 3'h0, mon_reg[1], 3'h0, mon_reg[0]};
      `ODL_STATUS:   rd_val = {23'h0, primary_sel, 6'h0, live_reg};
      `ODL_INT_STAT: rd_val = {30'h0, stat_reg};
      `ODL_INT_MASK: rd_val = {30'h0, mask_reg};
      default: begin
        if (ra_div) rd_val = {24'h0, div_reg[ra_dix]};
        else rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= ODL_OKAY;
    end else if (ce) begin
      arready <= ~rv_next;
      rvalid  <= rv_next;
      if (ar_take) begin
        rdata <= rd_val;
        rresp <= rd_ok ? ODL_OKAY : ODL_SLVERR;
      end
    end
  end

  // Integer channels: count source edges, output high for first half of the ratio
  logic [7:0] icnt_reg [4];
  logic [7:0] icnt_next [4];
  logic [3:0] ch_next;
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      icnt_next[c] = icnt_reg[c];
      if (src_rise) icnt_next[c] = (icnt_reg[c] + 8'h01 >= div_reg[c]) ? 8'h00
                                                                          : icnt_reg[c] + 8'h01;
      ch_next[c] = (div_reg[c] == 8'h01) ? src_lvl
                 : (icnt_next[c] < 8'((9'(div_reg[c]) + 9'h001) >> 1));
    end
  end

  // Fractional channel: each half period is int or int+1 edges by fraction carry
  logic [4:0]  fcnt_reg;
  logic [23:0] facc_reg;
  logic [4:0]  flim_reg;
  wire  [24:0] facc_sum  = {1'b0, facc_reg} + {1'b0, ffrac_reg};
  wire         f_wrap    = src_rise && (fcnt_reg + 5'h01 >= flim_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      icnt_reg    <= '{default: 8'h00};
      channel_out <= 4'h0;
      fcnt_reg    <= 5'h00;
      facc_reg    <= 24'h0;
      flim_reg    <= 5'h01;
      frac_out    <= 1'b0;
    end else if (ce) begin
      icnt_reg    <= icnt_next;
      channel_out <= ch_next;
      if (f_wrap) begin
        fcnt_reg <= 5'h00;
        frac_out <= ~frac_out;
        facc_reg <= facc_sum[23:0];
        flim_reg <= {1'b0, fint_reg} + {4'h0, facc_sum[24]};
      end else if (src_rise) begin
        fcnt_reg <= fcnt_reg + 5'h01;
      end
    end
  end

  // Loss monitors, one per input, ticking on loop one divided by its ratio
  logic [4:0] mdiv_reg [2];
  logic [1:0] miss_reg [2];
  logic [7:0] good_reg [2];
  logic [1:0] seen_reg;
  logic [1:0] tick, edge_in, seen_now, lost_set, lost_clr, live_next;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      tick[i]      = rise[0] && (mdiv_reg[i] + 5'h01 >= mon_reg[i]);
      edge_in[i]   = rise[2 + i];
      seen_now[i]  = seen_reg[i] | edge_in[i];
      lost_set[i]  = filt_reg[4 + i]
                   | (tick[i] && !seen_now[i] && miss_reg[i] + 2'h1 >= `ODL_MISS_LIMIT);
      lost_clr[i]  = live_reg[i] && tick[i] && seen_now[i]
                   && (good_reg[i] + 8'h01 >= reval_reg);
      live_next[i] = bypass ? 1'b0
                   : lost_set[i] ? 1'b1 : (lost_clr[i] ? 1'b0 : live_reg[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdiv_reg <= '{default: 5'h00};
      miss_reg <= '{default: 2'h0};
      good_reg <= '{default: 8'h00};
      seen_reg <= 2'h0;
      live_reg <= 2'h0;
    end else if (ce) begin
      live_reg <= live_next;
      for (int i = 0; i < 2; i++) begin
        if (bypass) begin
          mdiv_reg[i] <= 5'h00;
          miss_reg[i] <= 2'h0;
          good_reg[i] <= 8'h00;
          seen_reg[i] <= 1'b0;
        end else begin
          if (rise[0]) mdiv_reg[i] <= tick[i] ? 5'h00 : mdiv_reg[i] + 5'h01;
          seen_reg[i] <= tick[i] ? 1'b0 : seen_now[i];
          if (tick[i]) begin
            // Saturate so a long outage does not wrap back to "present"
            miss_reg[i] <= seen_now[i] ? 2'h0
                         : (miss_reg[i] == `ODL_MISS_LIMIT ? miss_reg[i] : miss_reg[i] + 2'h1);
            // Zero differential voltage is not a present signal: restart the count
            good_reg[i] <= (seen_now[i] && live_reg[i] && !lost_clr[i]
                            && !filt_reg[4 + i])
                         ? good_reg[i] + 8'h01 : 8'h00;
          end
        end
      end
    end
  end

  // Sticky flags, interrupt and input selection
  wire [1:0] loss_ev  = live_next & ~live_reg;
  wire [1:0] w1c      = (do_wr && wa_ist) ? ist_w[1:0] : 2'h0;
  wire [1:0] st_next  = loss_ev | (stat_reg & ~w1c);
  wire       pri_lost = live_reg[primary_sel];
  wire       sec_ok   = ~live_reg[~primary_sel];
  wire       man_sel  = ctrl_reg[`ODL_CTRL_MSEL];
  // Auto switch only to a healthy secondary, otherwise hold the current input
  wire       pri_next = auto_sel ? ((pri_lost && sec_ok) ? ~primary_sel : primary_sel)
                                 : man_sel;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg                <= 2'h0;
      primary_sel             <= 1'b0;
      interrupt_request_out_n <= 1'b1;
    end else if (ce) begin
      stat_reg                <= st_next;
      primary_sel             <= pri_next;
      interrupt_request_out_n <= ~|(st_next & mask_reg);
    end
  end

endmodule

// *** shared/odl_defines.svh ***
// Purpose: Offsets, field positions, reset values and counts of the divider/monitor block
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one register per word
// Notes:   Included by its bare name
`ifndef ODL_DEFINES_SVH
`define ODL_DEFINES_SVH

`define ODL_AW          6
`define ODL_CTRL        6'h00
`define ODL_DIV0        6'h04
`define ODL_DIV1        6'h08
`define ODL_DIV2        6'h0c
`define ODL_DIV3        6'h10
`define ODL_FRAC        6'h14
`define ODL_MON         6'h18
`define ODL_STATUS      6'h1c
`define ODL_INT_STAT    6'h20
`define ODL_INT_MASK    6'h24

`define ODL_CTRL_DIVSEL 0
`define ODL_CTRL_BYP   1
`define ODL_CTRL_AUTO   2
`define ODL_CTRL_MSEL   3
`define ODL_FRAC_INT_LSB 24
`define ODL_MON1_LSB    8
`define ODL_REVAL_LSB   16
`define ODL_ST_PRI      8

`define ODL_CTRL_RST    4'h0
`define ODL_DIV_RST     8'h01
`define ODL_FINT_RST    4'h1
`define ODL_FFRAC_RST   24'h000000
`define ODL_MON_RST     5'h01
`define ODL_REVAL_RST   8'h04
`define ODL_MISS_LIMIT  2'h3

`endif

// *** shared/odl_pkg.sv ***
// Purpose: Types shared by the divider/monitor block
// Assumes: Constants live in odl_defines.svh
// Notes:   Response codes follow AXI4-Lite
package odl_pkg;
  typedef enum logic [1:0] {
    ODL_OKAY   = 2'h0,
    ODL_SLVERR = 2'h2
  } odl_resp_e;
  typedef logic [31:0] odl_word_t;
endpackage

// *** verification/odl_chk.sv ***
// Purpose: Bus handshake and reset checks on the divider/monitor block ports
// Assumes: ce taken low by the bench only while the bus is idle
// Notes:   Attached to odl_top by bind
`timescale 1ns/10ps
`include "odl_defines.svh"
module odl_chk (
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               ce,
  // Write
  input wire logic               awvalid,
  input wire logic               awready,
  input wire logic               wvalid,
  input wire logic               wready,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire odl_pkg::odl_resp_e bresp,
  // Read
  input wire logic               arvalid,
  input wire logic               arready,
  input wire logic [5:0]         araddr,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire odl_pkg::odl_word_t rdata,
  input wire odl_pkg::odl_resp_e rresp,
  // Interrupt
  input wire logic               interrupt_request_out_n
);
  import odl_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready && ce;
  endsequence
  sequence s_ar_take;
    arvalid && arready && ce;
  endsequence
  a_rst_idle: assert property ($rose(aresetn) |-> awready && wready && arready && !bvalid
    && !rvalid && interrupt_request_out_n) else $error("not idle after reset");
  a_wr_answer: assert property (s_wr_take |=> !bvalid ##1 bvalid) else $error("late bvalid");
  a_rd_answer: assert property (s_ar_take |=> rvalid) else $error("late rvalid");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer moved");
  a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer moved");
  a_rd_block: assert property (rvalid |-> !arready) else $error("arready while pending");
  a_wr_block: assert property (bvalid |-> !awready && !wready) else $error("ready while pending");
  a_rd_unmap: assert property (s_ar_take ##0 araddr > `ODL_INT_MASK |=> rresp == ODL_SLVERR
    && rdata == 32'h0) else $error("unmapped read not refused");
  a_rd_mapped: assert property (s_ar_take ##0 araddr <= `ODL_INT_MASK && araddr[1:0] == 2'h0
    |=> rresp == ODL_OKAY) else $error("mapped read refused");
endmodule
bind odl_top odl_chk u_chk (.aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
  .interrupt_request_out_n);

// *** verification/odl_clk_src.sv ***
// Purpose: Loop and reference clock sources facing the monitor block
// Assumes: Loop one 2.5 MHz, loop two 5 MHz
// Notes:   A stopped reference stands low, as an idle driver would
`timescale 1ns/10ps
module odl_clk_src (
  // Controls
  input wire logic       [1:0] run_ref,
  input wire logic             fast_ref0,
  // Clocks
  output logic                 loop1_clk,
  output logic                 loop2_clk,
  output logic           [1:0] ref_clk_in
);
  logic l1 = 1'b0;
  logic l2 = 1'b0;
  logic rf = 1'b0;
  // Odd offset keeps source edges off aclk edges
  initial begin
    #3;
    forever #100 begin
      l2 = ~l2;
      if (l2) l1 = ~l1;
    end
  end
  // Same rate as loop one, quarter period late, so ratio 1 matches
  always @(l1) rf <= #100 l1;
  assign loop1_clk = l1;
  assign loop2_clk = l2;
  // Double rate on demand: wrong frequency, no missing edges
  assign ref_clk_in[0] = (fast_ref0 ? l2 : rf) & run_ref[0];
  assign ref_clk_in[1] = rf & run_ref[1];
endmodule

// *** verification/odl_top_tb_top.sv ***
// Purpose: Register, divider and loss monitor tests of the divider/monitor block
// Assumes: ce driven by the bench; clocks from odl_clk_src
// Notes:   Divider rates checked by edge counts over fixed windows
`timescale 1ns/10ps
`include "odl_defines.svh"
module odl_top_tb_top;
  import odl_pkg::*;
  logic       aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic       arvalid, arready, rvalid, rready, loop1_clk, loop2_clk, frac_out;
  logic       primary_sel, interrupt_request_out_n, fast, ce;
  logic [5:0] awaddr, araddr;
  logic [3:0] wstrb, channel_out;
  logic [1:0] ref_clk_in, ref_diff_zero, run_ref;
  odl_word_t  wdata, rdata, d;
  odl_resp_e  bresp, rresp, r;
  int         fail_count, compares, i;
  int         cc [5];
  logic [7:0] lg [20] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0a, 8'h10, 8'h14,
    8'h1e, 8'h20, 8'h28, 8'h32, 8'h3c, 8'h40, 8'h50, 8'h64, 8'h78, 8'h80, 8'ha0};
  logic [5:0] ra [10] = '{`ODL_CTRL, `ODL_DIV0, `ODL_DIV1, `ODL_DIV2, `ODL_DIV3, `ODL_FRAC,
    `ODL_MON, `ODL_STATUS, `ODL_INT_STAT, `ODL_INT_MASK};
  odl_word_t  rv [10] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h01000000, 32'h00040101,
    32'h0, 32'h0, 32'h0};
  odl_clk_src src (.run_ref(run_ref), .fast_ref0(fast), .loop1_clk, .loop2_clk, .ref_clk_in);
  odl_top dut (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp, .loop1_clk, .loop2_clk, .ref_clk_in, .ref_diff_zero, .channel_out,
    .frac_out, .primary_sel, .interrupt_request_out_n);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input odl_word_t seen, input odl_word_t exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      fail_count++;
      summarize();
    end
  endtask
  // Answers are stalled one cycle on purpose to exercise the hold
  task automatic wr(input logic [5:0] a, input odl_word_t v, input logic [3:0] s);
    logic aw, w;
    int   n;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    for (n = 0; n < 200 && !(aw && w); n++) begin
      @(posedge aclk);
      aw = aw | awready;
      w = w | wready;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    tmo(n);
    for (n = 0; n < 200 && bvalid !== 1'b1; n++) @(posedge aclk);
    tmo(n);
    bready <= 1'b1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    for (n = 0; n < 200 && rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    tmo(n);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [5:0] a, input odl_word_t e);
    rd(a);
    chk(d, e);
  endtask
  task automatic poll(input odl_word_t e);
    int n;
    d = ~e;
    for (n = 0; n < 60 && d !== e; n++) rd(`ODL_STATUS);
    chk(d, e);
  endtask
  task automatic near(input int v, input int e);
    chk(32'(v >= e - 1 && v <= e + 1), 32'h1);
  endtask
  task automatic cnt(input int n);
    logic [4:0] p, q;
    cc = '{default: 0};
    repeat (n) begin
      p = {frac_out, channel_out};
      @(posedge aclk);
      q = {frac_out, channel_out};
      for (int k = 0; k < 5; k++) cc[k] += int'(q[k] & ~p[k]);
    end
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fast} = 7'h0;
    ce = 1'b1;
    {awaddr, araddr, wdata, wstrb, ref_diff_zero} = 50'h0;
    run_ref = 2'h3;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (40) @(posedge aclk);
    for (i = 0; i < 10; i++) rc(ra[i], rv[i]);
    rd(6'h28);
    chk(d, 32'h0);
    chk(32'(r), 32'(ODL_SLVERR));
    wr(6'h28, 32'h5, 4'hf);
    chk(32'(r), 32'(ODL_SLVERR));
    for (i = 0; i < 20; i++) begin
      wr(`ODL_DIV0 + 6'(4 * (i % 4)), 32'(lg[i]), 4'hf);
      rc(`ODL_DIV0 + 6'(4 * (i % 4)), 32'(lg[i]));
    end
    wr(`ODL_DIV1, 32'h7, 4'hf);
    rc(`ODL_DIV1, 32'h78);
    wr(`ODL_DIV2, 32'ha1, 4'hf);
    rc(`ODL_DIV2, 32'h80);
    wr(`ODL_FRAC, 32'h0f000000, 4'hf);
    rc(`ODL_FRAC, 32'h01000000);
    wr(`ODL_FRAC, 32'h02000000, 4'hf);
    rc(`ODL_FRAC, 32'h02000000);
    wr(`ODL_MON, 32'h00ffff03, 4'h1);
    rc(`ODL_MON, 32'h00040103);
    wr(`ODL_MON, 32'h00040101, 4'hf);
    wr(`ODL_DIV0, 32'h2, 4'hf);
    wr(`ODL_DIV1, 32'h4, 4'hf);
    wr(`ODL_DIV2, 32'h1, 4'hf);
    wr(`ODL_DIV3, 32'h5, 4'hf);
    cnt(640);
    near(cc[0], 40);
    near(cc[1], 20);
    near(cc[2], 80);
    near(cc[3], 16);
    near(cc[4], 20);
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    cnt(200);
    chk(32'(cc[2] + cc[4]), 32'h0);
    ce <= 1'b1;
    wr(`ODL_CTRL, 32'h1, 4'hf);
    wr(`ODL_FRAC, 32'h02800000, 4'hf);
    cnt(640);
    near(cc[0], 20);
    near(cc[4], 8);
    wr(`ODL_CTRL, 32'h0, 4'hf);
    wr(`ODL_INT_MASK, 32'h1, 4'hf);
    run_ref[0] <= 1'b0;
    repeat (16) @(posedge aclk);
    rc(`ODL_STATUS, 32'h0);
    poll(32'h1);
    rc(`ODL_INT_STAT, 32'h1);
    chk(32'(interrupt_request_out_n), 32'h0);
    run_ref[0] <= 1'b1;
    repeat (16) @(posedge aclk);
    rc(`ODL_STATUS, 32'h1);
    poll(32'h0);
    rc(`ODL_INT_STAT, 32'h1);
    wr(`ODL_INT_STAT, 32'h1, 4'hf);
    rc(`ODL_INT_STAT, 32'h0);
    chk(32'(interrupt_request_out_n), 32'h1);
    ref_diff_zero <= 2'h2;
    poll(32'h2);
    chk(32'(interrupt_request_out_n), 32'h1);
    ref_diff_zero <= 2'h0;
    repeat (16) @(posedge aclk);
    rc(`ODL_STATUS, 32'h2);
    poll(32'h0);
    wr(`ODL_INT_STAT, 32'h2, 4'hf);
    ref_diff_zero <= 2'h1;
    poll(32'h1);
    rc(`ODL_INT_STAT, 32'h1);
    ref_diff_zero <= 2'h0;
    poll(32'h0);
    wr(`ODL_INT_STAT, 32'h3, 4'hf);
    fast <= 1'b1;
    repeat (200) @(posedge aclk);
    rc(`ODL_STATUS, 32'h0);
    fast <= 1'b0;
    wr(`ODL_CTRL, 32'ha, 4'hf);
    run_ref[1] <= 1'b0;
    repeat (200) @(posedge aclk);
    rc(`ODL_STATUS, 32'h100);
    chk(32'(primary_sel), 32'h1);
    rc(`ODL_INT_STAT, 32'h0);
    run_ref[1] <= 1'b1;
    wr(`ODL_CTRL, 32'h0, 4'hf);
    repeat (100) @(posedge aclk);
    rc(`ODL_STATUS, 32'h0);
    wr(`ODL_CTRL, 32'h4, 4'hf);
    run_ref[0] <= 1'b0;
    poll(32'h101);
    chk(32'(primary_sel), 32'h1);
    summarize();
  end
endmodule
